// [rtl/ctl_pkg.sv]
// Shared constants, types and helpers for the converter control port.
package ctl_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and filter timing.
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FCNT_W = 3;
	localparam logic [FCNT_W-1:0] SPIKE_LAST = FCNT_W'(SPIKE_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Command word layout of the select-based port.
	localparam int WORD_BITS = 16;
	localparam int RW_BIT = 15;
	localparam int IDX_MSB = 14;
	localparam int IDX_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam logic [4:0] READ_START_CNT = 5'h07;
	localparam logic [4:0] LAST_BIT_CNT = 5'h0f;
	localparam logic [4:0] WORD_DONE_CNT = 5'h10;

	////////////////////////////////////////////////////////////////////////////
	// Two-wire slave layout.
	localparam logic [4:0] ADDR_PREFIX = 5'h13;
	localparam logic [3:0] BYTE_DONE_CNT = 4'h8;
	localparam logic [6:0] IDX_WRAP = 7'h7f;
	localparam logic [6:0] IDX_STEP = 7'h01;

	////////////////////////////////////////////////////////////////////////////
	// Register map: defined registers start at DEF_BASE.
	localparam logic [6:0] DEF_BASE = 7'h10;
	localparam int REG_COUNT = 8;

	// Filtered input positions.
	localparam int IN_SCL = 0;
	localparam int IN_SDA = 1;
	localparam int IN_A0 = 2;
	localparam int IN_A1 = 3;
	localparam int IN_CONTROL_INTERFACE_SELECT = 4;
	localparam int IN_N = 5;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_IDX,
		ST_IDX_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RACK
	} i2c_state_t;

	function automatic logic is_def(input logic [6:0] i, input int n);
		return (int'(i) >= int'(DEF_BASE)) && (int'(i) < int'(DEF_BASE) + n);
	endfunction

endpackage

// [rtl/dac_control_port.sv]
// Control port core: mode select, two-wire slave, register file.
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Select-port command is one 16-bit word, MSB first; bit 15 is direction.
// [RQ2] Direction 0 writes a register, direction 1 reads one.
// [RQ3] Bits 14-8 hold the register index, bits 7-0 the data byte.
// [RQ4] Host holds select high when idle and pulls it low per word.
// [RQ5] Host gives exactly sixteen shift clocks per word.
// [RQ6] On read, the indexed register is driven out after the eighth clock.
// [RQ7] On write, the byte is stored only after the sixteenth clock.
// [RQ8] Host raises select at least once between words.
// [RQ9] Interface-select low picks the select port, high the two-wire slave.
// [RQ10] Select port shifts on its own clock, independent of the system clock.
// [RQ11] Two-wire side is slave only and never makes start or stop.
// [RQ12] Two-wire mode reuses select, mute, shift clock and data-in pins.
// [RQ13] Slave address is 10011 then address bit high then address bit low.
// [RQ14] Only a matching address is acknowledged and served.
// [RQ15] Write is address, index byte, data bytes; each accepted byte acked.
// [RQ16] Index advances by one after each received data byte.
// [RQ17] Index wraps from 0x7F to 0x00.
// [RQ18] Writes to undefined registers are not acknowledged.
// [RQ19] Read follows index write and repeated start; index advances per byte.
// [RQ20] First read after a write returns the current index unadvanced.
// [RQ21] Reads of 0x10 to 0x1F always return a byte.
// [RQ22] Master repeats the address and ends reads with not-acknowledge and stop.
// [RQ23] Both two-wire lines are spike-filtered on the system clock.
// [RQ24] Filter has known limits at very slow or very fast system clocks.
// [RQ25] Select rising early discards the partial word without side effects.
module dac_control_port import ctl_pkg::*; #(
	parameter int NUM_REGS = REG_COUNT
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic control_interface_select_i,
	input wire logic port_select_n_i,
	input wire logic port_shift_clock_i,
	input wire logic port_serial_in_i,
	input wire logic mute_i,
	output logic port_serial_in_o,
	output logic port_serial_in_oe_o,
	output logic port_serial_out_o,
	output logic [NUM_REGS*8-1:0] mode_regs_o
);

	typedef struct packed {
		logic [IN_N-1:0] s1;
		logic [IN_N-1:0] s2;
		logic [IN_N-1:0] s3;
		logic [IN_N-1:0] filt;
		logic [IN_N-1:0][FCNT_W-1:0] fcnt;
		logic t1;
		logic t2;
		logic t3;
		logic tacc;
		i2c_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [6:0] idx;
		logic fresh;
		logic lastw;
		logic rw;
		logic mack;
		logic sda_oe;
		logic sda_lvl;
		logic [NUM_REGS-1:0][7:0] regs;
	} core_t;

	core_t c_ff, nxt_c;
	logic spi_ev;
	logic spi_sel_n;
	logic [IN_N-1:0] pins;

	spi_link_if #(.NUM_REGS(NUM_REGS)) link();

	// The interface-select strap is static in use; in two-wire mode the select
	// pin is an address input, so the shifter is held in abort.
	assign spi_sel_n = port_select_n_i | c_ff.filt[IN_CONTROL_INTERFACE_SELECT]; // [RQ9]

	spi_shifter #(.NUM_REGS(NUM_REGS)) u_shift (
		.port_shift_clock_i(port_shift_clock_i),
		.port_select_n_i(spi_sel_n),
		.resetn_i(resetn_i),
		.port_serial_in_i(port_serial_in_i),
		.port_serial_out_o(port_serial_out_o),
		.link(link.shifter)
	);

	assign link.regs = c_ff.regs;
	// In two-wire mode the pins take new roles.
	assign pins = {control_interface_select_i, mute_i, port_select_n_i,
		port_serial_in_i, port_shift_clock_i}; // [RQ12]
	assign spi_ev = (c_ff.t2 == c_ff.t3) && (c_ff.t3 != c_ff.tacc);

	function automatic logic [7:0] rd_byte(input logic [6:0] i, input core_t c);
		logic [7:0] b;
		b = 8'h00;
		for (int k = 0; k < NUM_REGS; k++) begin
			if (int'(i) == int'(DEF_BASE) + k) begin
				b = c.regs[k];
			end
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic i2c;
		logic scl_r;
		logic scl_f;
		logic start;
		logic stop;
		logic [6:0] tgt;
		logic [7:0] b;
		i2c = 1'b0;
		scl_r = 1'b0;
		scl_f = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		tgt = 7'h00;
		b = 8'h00;
		nxt_c = c_ff;
		nxt_c.s1 = pins;
		nxt_c.s2 = c_ff.s1;
		nxt_c.s3 = c_ff.s2;
		// A line change is taken only after it has held for the spike window.
		// At this clock rate the window is short of a slow-clock filter, so
		// long glitches near SCL falling can still mimic a start or stop.
		for (int i = 0; i < IN_N; i++) begin
			if (c_ff.s2[i] == c_ff.s3[i] && c_ff.s3[i] != c_ff.filt[i]) begin
				if (c_ff.fcnt[i] == SPIKE_LAST) begin
					nxt_c.filt[i] = c_ff.s3[i]; // [RQ23]
					nxt_c.fcnt[i] = '0;
				end else begin
					nxt_c.fcnt[i] = c_ff.fcnt[i] + FCNT_W'(1);
				end
			end else begin
				nxt_c.fcnt[i] = '0; // [RQ24]
			end
		end
		i2c = c_ff.filt[IN_CONTROL_INTERFACE_SELECT];
		scl_r = !c_ff.filt[IN_SCL] && nxt_c.filt[IN_SCL];
		scl_f = c_ff.filt[IN_SCL] && !nxt_c.filt[IN_SCL];
		start = c_ff.filt[IN_SCL] && nxt_c.filt[IN_SCL] && c_ff.filt[IN_SDA] && !nxt_c.filt[IN_SDA];
		stop = c_ff.filt[IN_SCL] && nxt_c.filt[IN_SCL] && !c_ff.filt[IN_SDA] && nxt_c.filt[IN_SDA];

		// Select-port word handed across by toggle.
		nxt_c.t1 = link.tgl;
		nxt_c.t2 = c_ff.t1;
		nxt_c.t3 = c_ff.t2;
		if (spi_ev) begin
			nxt_c.tacc = c_ff.t3;
			if (!i2c && !link.word[RW_BIT] && is_def(link.word[IDX_MSB:IDX_LSB], NUM_REGS)) begin // [RQ2]
				tgt = link.word[IDX_MSB:IDX_LSB]; // [RQ3]
				nxt_c.regs[int'(tgt) - int'(DEF_BASE)] = link.word[DATA_MSB:0]; // [RQ7]
			end
		end

		if (!i2c) begin
			nxt_c.st = ST_IDLE;
			nxt_c.sda_oe = 1'b0; // [RQ9]
		end else if (start) begin
			nxt_c.st = ST_ADDR;
			nxt_c.cnt = 4'h0;
			nxt_c.sda_oe = 1'b0;
		end else if (stop) begin
			nxt_c.st = ST_IDLE;
			nxt_c.sda_oe = 1'b0;
		end else if (scl_r) begin
			case (c_ff.st)
				ST_ADDR, ST_IDX, ST_WDATA: begin
					if (c_ff.cnt < BYTE_DONE_CNT) begin
						nxt_c.sh = {c_ff.sh[6:0], c_ff.s3[IN_SDA]};
						nxt_c.cnt = c_ff.cnt + 4'h1;
					end
				end
				ST_RDATA: begin
					nxt_c.cnt = c_ff.cnt + 4'h1;
				end
				ST_RACK: begin
					nxt_c.mack = !c_ff.s3[IN_SDA];
				end
				default: begin
				end
			endcase
		end else if (scl_f) begin
			// The slave only drives SDA low after SCL falls, never while high.
			case (c_ff.st) // [RQ11]
				ST_ADDR: begin
					if (c_ff.cnt == BYTE_DONE_CNT) begin
						if (c_ff.sh[7:1] == {ADDR_PREFIX, c_ff.filt[IN_A1], c_ff.filt[IN_A0]}) begin // [RQ13]
							nxt_c.rw = c_ff.sh[0];
							nxt_c.sda_oe = 1'b1; // [RQ14]
							nxt_c.st = ST_ADDR_ACK;
							nxt_c.lastw = !c_ff.sh[0];
							if (c_ff.sh[0] && c_ff.lastw) begin
								nxt_c.fresh = 1'b1; // [RQ20]
							end
						end else begin
							nxt_c.st = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					nxt_c.cnt = 4'h0;
					nxt_c.sda_oe = 1'b0;
					if (c_ff.rw) begin
						tgt = c_ff.fresh ? c_ff.idx : c_ff.idx + IDX_STEP; // [RQ19]
						b = rd_byte(tgt, c_ff); // [RQ21]
						nxt_c.idx = tgt;
						nxt_c.fresh = 1'b0;
						nxt_c.sh = b;
						nxt_c.sda_oe = !b[7];
						nxt_c.st = ST_RDATA;
					end else begin
						nxt_c.st = ST_IDX;
					end
				end
				ST_IDX: begin
					if (c_ff.cnt == BYTE_DONE_CNT) begin
						nxt_c.idx = c_ff.sh[6:0];
						nxt_c.fresh = 1'b1;
						nxt_c.sda_oe = 1'b1; // [RQ15]
						nxt_c.st = ST_IDX_ACK;
					end
				end
				ST_IDX_ACK, ST_WDATA_ACK: begin
					nxt_c.sda_oe = 1'b0;
					nxt_c.cnt = 4'h0;
					nxt_c.st = ST_WDATA;
				end
				ST_WDATA: begin
					if (c_ff.cnt == BYTE_DONE_CNT) begin
						// Wrap from 0x7F to 0x00 falls out of the 7-bit sum.
						tgt = c_ff.fresh ? c_ff.idx : c_ff.idx + IDX_STEP; // [RQ16]
						nxt_c.idx = tgt; // [RQ17]
						nxt_c.fresh = 1'b0;
						if (is_def(tgt, NUM_REGS)) begin
							nxt_c.regs[int'(tgt) - int'(DEF_BASE)] = c_ff.sh;
							nxt_c.sda_oe = 1'b1; // [RQ15]
						end else begin
							nxt_c.sda_oe = 1'b0; // [RQ18]
						end
						nxt_c.st = ST_WDATA_ACK;
					end
				end
				ST_RDATA: begin
					if (c_ff.cnt == BYTE_DONE_CNT) begin
						nxt_c.sda_oe = 1'b0;
						nxt_c.st = ST_RACK;
					end else begin
						nxt_c.sh = {c_ff.sh[6:0], 1'b0};
						nxt_c.sda_oe = !c_ff.sh[6];
					end
				end
				ST_RACK: begin
					if (c_ff.mack) begin
						tgt = c_ff.idx + IDX_STEP; // [RQ19]
						b = rd_byte(tgt, c_ff);
						nxt_c.idx = tgt;
						nxt_c.sh = b;
						nxt_c.sda_oe = !b[7];
						nxt_c.cnt = 4'h0;
						nxt_c.st = ST_RDATA;
					end else begin
						nxt_c.st = ST_IDLE; // [RQ22]
					end
				end
				default: begin
					nxt_c.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			c_ff <= '0;
		end else begin
			c_ff <= nxt_c;
		end
	end

	assign port_serial_in_o = c_ff.sda_lvl;
	assign port_serial_in_oe_o = c_ff.sda_oe;
	assign mode_regs_o = c_ff.regs;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_spi_quiet;
		!c_ff.filt[IN_CONTROL_INTERFACE_SELECT] |=> !port_serial_in_oe_o;
	endproperty
	a_spi_quiet: assert property (p_spi_quiet) else $error("SDA driven in select mode"); // [RQ9]

	property p_drive_states;
		port_serial_in_oe_o |-> c_ff.st inside {ST_ADDR_ACK, ST_IDX_ACK, ST_WDATA_ACK, ST_RDATA};
	endproperty
	a_drive_states: assert property (p_drive_states) else $error("SDA driven in wrong phase"); // [RQ11]

	property p_addr_match;
		$rose(c_ff.sda_oe) && c_ff.st == ST_ADDR_ACK |->
			$past(c_ff.sh[7:1]) == {ADDR_PREFIX, $past(c_ff.filt[IN_A1]), $past(c_ff.filt[IN_A0])};
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("acked a foreign address"); // [RQ14]

	property p_step;
		$changed(c_ff.idx) && $past(c_ff.st) != ST_IDX |-> c_ff.idx == $past(c_ff.idx) + IDX_STEP;
	endproperty
	a_step: assert property (p_step) else $error("index moved by other than one"); // [RQ16]

	property p_wrap;
		$changed(c_ff.idx) && $past(c_ff.st) != ST_IDX && $past(c_ff.idx) == IDX_WRAP
			|-> c_ff.idx == 7'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("index did not wrap"); // [RQ17]

	property p_nack_undef;
		$past(c_ff.st) == ST_WDATA && c_ff.st == ST_WDATA_ACK |->
			c_ff.sda_oe == is_def(c_ff.idx, NUM_REGS);
	endproperty
	a_nack_undef: assert property (p_nack_undef) else $error("wrong ack on data byte"); // [RQ18]

	property p_read_first;
		$past(c_ff.st) == ST_ADDR_ACK && c_ff.st == ST_RDATA && $past(c_ff.fresh)
			|-> c_ff.idx == $past(c_ff.idx);
	endproperty
	a_read_first: assert property (p_read_first) else $error("first read advanced index"); // [RQ20]

	property p_read_keeps;
		spi_ev && !c_ff.filt[IN_CONTROL_INTERFACE_SELECT] && link.word[RW_BIT] |=> $stable(c_ff.regs);
	endproperty
	a_read_keeps: assert property (p_read_keeps) else $error("read word changed a register"); // [RQ2]

	property p_filter;
		$changed(c_ff.filt[IN_SCL]) |-> $past(c_ff.fcnt[IN_SCL]) == SPIKE_LAST;
	endproperty
	a_filter: assert property (p_filter) else $error("SCL change passed filter early"); // [RQ23]

	c_i2c_write: cover property (c_ff.st == ST_WDATA_ACK && c_ff.sda_oe);
	c_i2c_nack: cover property (c_ff.st == ST_WDATA_ACK && !c_ff.sda_oe);
	c_i2c_read: cover property (c_ff.st == ST_RACK ##1 c_ff.st == ST_RDATA);
	c_spi_word: cover property (spi_ev && !c_ff.filt[IN_CONTROL_INTERFACE_SELECT]);

endmodule

// [rtl/spi_link_if.sv]
// Carrier between the shift-clock logic and the system-clock core.
`timescale 1ns/1ps
interface spi_link_if #(parameter int NUM_REGS = 8);
	logic [ctl_pkg::WORD_BITS-1:0] word;
	logic tgl;
	logic [NUM_REGS*8-1:0] regs;
	modport shifter(output word, output tgl, input regs);
	modport core(input word, input tgl, output regs);
endinterface

// [rtl/spi_shifter.sv]
// Select-based serial port logic running on the port's own shift clock.
`timescale 1ns/1ps
module spi_shifter import ctl_pkg::*; #(
	parameter int NUM_REGS = REG_COUNT
) (
	input wire logic port_shift_clock_i,
	input wire logic port_select_n_i,
	input wire logic resetn_i,
	input wire logic port_serial_in_i,
	output logic port_serial_out_o,
	spi_link_if.shifter link
);

	typedef struct packed {
		logic [4:0] cnt;
		logic [14:0] sh;
		logic rd;
		logic [7:0] rbyte;
	} shift_t;

	typedef struct packed {
		logic [WORD_BITS-1:0] word;
		logic tgl;
	} hand_t;

	shift_t s_ff, nxt_s;
	hand_t h_ff, nxt_h;
	logic abort;
	logic [7:0] look;

	// A high select abandons any partial word, so nothing reaches the core.
	assign abort = port_select_n_i | ~resetn_i; // [RQ25]

	////////////////////////////////////////////////////////////////////////////
	// The readback image only changes after a completed write; a read in the
	// word that follows a write may see the old byte if the core is still
	// catching up, which needs the host to pause a few system clocks.
	always_comb begin
		look = 8'h00;
		for (int k = 0; k < NUM_REGS; k++) begin
			if (int'({s_ff.sh[5:0], port_serial_in_i}) == int'(DEF_BASE) + k) begin
				look = link.regs[k*8 +: 8]; // [RQ21]
			end
		end
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_h = h_ff;
		if (s_ff.cnt < WORD_DONE_CNT) begin // [RQ5]
			nxt_s.sh = {s_ff.sh[13:0], port_serial_in_i}; // [RQ1]
			nxt_s.cnt = s_ff.cnt + 5'h01;
			if (s_ff.cnt == READ_START_CNT) begin
				nxt_s.rd = s_ff.sh[6]; // [RQ2]
				nxt_s.rbyte = look; // [RQ3]
			end
			if (s_ff.cnt == LAST_BIT_CNT) begin
				nxt_h.word = {s_ff.sh, port_serial_in_i}; // [RQ7]
				nxt_h.tgl = ~h_ff.tgl;
			end
		end
	end

	always_ff @(posedge port_shift_clock_i or posedge abort) begin // [RQ10]
		if (abort) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	always_ff @(posedge port_shift_clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			h_ff <= '0;
		end else begin
			h_ff <= nxt_h;
		end
	end

	// Readback bits change on the falling shift clock, from the eighth onward.
	always_ff @(negedge port_shift_clock_i or posedge abort) begin
		if (abort) begin
			port_serial_out_o <= 1'b0;
		end else if (s_ff.rd && s_ff.cnt >= 5'h08 && s_ff.cnt < WORD_DONE_CNT) begin
			port_serial_out_o <= s_ff.rbyte[~s_ff.cnt[2:0]]; // [RQ6]
		end else begin
			port_serial_out_o <= 1'b0;
		end
	end

	assign link.word = h_ff.word;
	assign link.tgl = h_ff.tgl;

	////////////////////////////////////////////////////////////////////////////
	// Checked on the falling clock: select rises before any further rising edge.
	property p_hand_on_16;
		@(negedge port_shift_clock_i) disable iff (abort)
		$rose(s_ff.cnt == WORD_DONE_CNT) |-> h_ff.tgl != $past(h_ff.tgl);
	endproperty
	a_hand_on_16: assert property (p_hand_on_16) else $error("word not handed over"); // [RQ7]

	property p_hold_16;
		@(posedge port_shift_clock_i) disable iff (abort)
		s_ff.cnt == WORD_DONE_CNT |-> nxt_s == s_ff && nxt_h == h_ff;
	endproperty
	a_hold_16: assert property (p_hold_16) else $error("extra shift clock accepted"); // [RQ5]

	c_word: cover property (@(posedge port_shift_clock_i) disable iff (abort)
		s_ff.cnt == LAST_BIT_CNT);

endmodule

// [test/host_model.sv]
// Host master model driving the select port and the two-wire bus.
`timescale 1ns/1ps
module host_model (
	input wire logic i2c_mode_i,
	input wire logic sda_oe_i,
	input wire logic sdo_i,
	output logic sel_n_o,
	output logic sck_o,
	output logic sdi_o,
	output logic mute_o
);
	localparam int Q = 300;
	logic spi_sel_n = 1'b1;
	logic spi_ck = 1'b0;
	logic spi_d = 1'b0;
	logic scl = 1'b1;
	logic sda_low = 1'b0;
	logic [1:0] adr = 2'h0;
	// The data line is open drain with a pull-up, so it is high unless someone pulls it.
	wire logic sda_w = !(sda_low || sda_oe_i);

	assign sel_n_o = i2c_mode_i ? adr[0] : spi_sel_n;
	assign mute_o = adr[1];
	assign sck_o = i2c_mode_i ? scl : spi_ck;
	assign sdi_o = i2c_mode_i ? sda_w : spi_d;

	////////////////////////////////////////////////////////////////////////////
	// One word on a 32 ns shift clock that only runs inside the word.
	task automatic spi_word(input logic [15:0] w, input int nclk, output logic [7:0] rd);
		rd = 8'h00;
		#5.3 spi_sel_n = 1'b0;
		for (int k = 1; k <= nclk; k++) begin
			// Clocks past the sixteenth repeat the word's bits instead of reading past it.
			spi_d = w[(16-k) & 15];
			#15;
			if (k >= 9 && k <= 16) rd[16-k] = sdo_i;
			#1 spi_ck = 1'b1;
			#16 spi_ck = 1'b0;
		end
		#16 spi_sel_n = 1'b1;
		// A released data line flips so that a stale bit never passes for data.
		spi_d = ~spi_d;
		#120;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Two-wire master; data bits change only while the clock is low, start and stop change it while high.
	task automatic i2c_start();
		sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask

	task automatic i2c_stop();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask

	task automatic i2c_bit(input logic b, output logic r);
		sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda_w;
		#Q scl = 1'b0;
		#Q;
	endtask

	// A receiving master passes 8'hff and gives its answer in ack_in.
	task automatic i2c_byte(input logic [7:0] b, input logic ack_in,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
		i2c_bit(ack_in, ack);
	endtask
endmodule

// [test/tb_dac_control_port.sv]
// Self-checking bench for the converter control port.
`timescale 1ns/1ps
module tb_dac_control_port;
	import ctl_pkg::*;
	localparam int LIMIT = 80000;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic control_interface_select_i = 1'b0;
	wire logic sel_n;
	wire logic sck;
	wire logic sdi;
	wire logic mute;
	logic sda_oe;
	logic sdo;
	logic sda_lvl;
	logic [REG_COUNT*8-1:0] regs;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int mem [128];
	logic [6:0] own;
	logic [7:0] d;
	logic [7:0] rd;

	always #4 clk_i = ~clk_i;

	dac_control_port #(.NUM_REGS(REG_COUNT)) dut (
		.clk_i(clk_i), .resetn_i(resetn_i),
		.control_interface_select_i(control_interface_select_i),
		.port_select_n_i(sel_n), .port_shift_clock_i(sck), .port_serial_in_i(sdi),
		.mute_i(mute), .port_serial_in_o(sda_lvl), .port_serial_in_oe_o(sda_oe),
		.port_serial_out_o(sdo), .mode_regs_o(regs));

	host_model host (.i2c_mode_i(control_interface_select_i), .sda_oe_i(sda_oe),
		.sdo_i(sdo), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi), .mute_o(mute));

	////////////////////////////////////////////////////////////////////////////
	function automatic logic defd(input int i);
		return i >= int'(DEF_BASE) && i < int'(DEF_BASE) + REG_COUNT;
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_regs();
		for (int k = 0; k < REG_COUNT; k++) check("mode_regs", regs[k*8+:8], 8'(mem[16+k]));
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// A start or repeated start, then the address byte; a missing ack reads as 1.
	task automatic i2c_addr(input logic [6:0] sa, input logic rw, input logic exp_ack);
		logic [7:0] r;
		logic ack;
		host.i2c_start();
		host.i2c_byte({sa, rw}, 1'b1, r, ack);
		check("addr_ack", {7'h00, ack}, {7'h00, !exp_ack});
	endtask

	task automatic i2c_send(input logic [7:0] b, input logic exp_ack);
		logic [7:0] r;
		logic ack;
		host.i2c_byte(b, 1'b1, r, ack);
		check("byte_ack", {7'h00, ack}, {7'h00, !exp_ack});
		// The data line is open drain: its driven level must always be low.
		check("sda_level", {7'h00, sda_lvl}, 8'h00);
	endtask

	task automatic i2c_recv(input int n, input logic nack);
		logic [7:0] r;
		logic ack;
		host.i2c_byte(8'hff, nack, r, ack);
		check("read_data", r, 8'(mem[n & 127]));
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 0;
		void'($urandom(32'hfa1ca866));
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		// Indices run from below to above the defined block, so both edges are hit.
		for (int n = 0; n < 12; n++) begin
			d = 8'($urandom);
			host.spi_word({1'b0, 7'h0e + 7'(n), d}, 16, rd);
			if (defd(14 + n)) mem[14+n] = d;
			repeat (8) @(posedge clk_i);
			check_regs();
			host.spi_word({1'b1, 7'h0e + 7'(n), ~d}, 16, rd);
			check("spi_read", rd, 8'(mem[14+n]));
		end
		$display("Test select port write and read done");
		for (int n = 8; n <= 15; n += 7) begin
			host.spi_word({1'b0, 7'h11, 8'($urandom)}, n, rd);
			repeat (8) @(posedge clk_i);
			check_regs();
		end
		// A seventeenth shift clock is ignored; the completed word still lands.
		d = 8'($urandom);
		host.spi_word({1'b0, 7'h11, d}, 17, rd);
		mem[17] = d;
		repeat (8) @(posedge clk_i);
		check_regs();
		$display("Test select port abort done");
		host.adr = 2'($urandom);
		own = {5'h13, host.adr};
		control_interface_select_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		i2c_addr(own, 1'b0, 1'b1);
		i2c_send(8'h16, 1'b1);
		for (int j = 32'h16; j <= 32'h18; j++) begin
			d = 8'($urandom);
			i2c_send(d, defd(j));
			if (defd(j)) mem[j] = d;
		end
		host.i2c_stop();
		repeat (8) @(posedge clk_i);
		check_regs();
		$display("Test two-wire write done");
		i2c_addr(own, 1'b0, 1'b1);
		i2c_send(8'h13, 1'b1);
		i2c_addr(own, 1'b1, 1'b1);
		for (int j = 32'h13; j <= 32'h15; j++) i2c_recv(j, j == 32'h15);
		host.i2c_stop();
		i2c_addr(own, 1'b1, 1'b1);
		i2c_recv(32'h16, 1'b1);
		host.i2c_stop();
		// Data bytes at 0x7f and then 0x00 are both undefined, across the wrap.
		i2c_addr(own, 1'b0, 1'b1);
		i2c_send(8'h7f, 1'b1);
		i2c_send(8'($urandom), 1'b0);
		i2c_send(8'($urandom), 1'b0);
		host.i2c_stop();
		// A read straight after a data write returns the register just written.
		i2c_addr(own, 1'b0, 1'b1);
		i2c_send(8'h14, 1'b1);
		d = 8'($urandom);
		i2c_send(d, 1'b1);
		mem[20] = d;
		i2c_addr(own, 1'b1, 1'b1);
		i2c_recv(32'h14, 1'b1);
		host.i2c_stop();
		$display("Test two-wire read done");
		for (int m = 0; m < 3; m++) begin
			i2c_addr(own ^ (7'h01 << (m * 3)), 1'b0, 1'b0);
			i2c_send(8'h10, 1'b0);
			i2c_send(8'h5a, 1'b0);
			host.i2c_stop();
		end
		check_regs();
		$display("Test two-wire foreign address done");
		control_interface_select_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		host.spi_word({1'b1, 7'h16, 8'h00}, 16, rd);
		check("spi_read", rd, 8'(mem[22]));
		$display("Test mode return done");
		finish_test();
	end
endmodule
